// file: design/aqs_params.svh
// Constants of the acquisition sequencer: register map, fields, reset values, sizes
`ifndef AQS_PARAMS_SVH
`define AQS_PARAMS_SVH
// What this block does
// - Software-timed mode: one conversion per command
// - Hardware-timed mode paced only by pacing clock
// - Buffered mode moves FIFO samples in blocks
// - Finite mode stops after count; reference needs finite
// - Continuous mode runs until stop command
// - Full FIFO overwrites oldest and flags overflow
// - Non-buffered mode: host reads FIFO directly
// - Start, reference, pause triggers from digital sources
// - Posttrigger count loaded, decremented per sample
// - Pretrigger count first, then posttrigger count
// - Reference trigger ignored before pretrigger samples done
// - After reference, count down posttrigger samples
// - Software start drives pulse on start line
// - Each pacing event samples every channel once
// - Pacing edge selectable rising or falling
// - Internal pacing: counter, software pulse, divided timebase
// - External pacing: terminals 0-5, lines 0-7, star
// - Pacing pulses ignored when not acquiring
// - Pacing pulses ignored while paused
// - Start-to-first-sample delay with divided-timebase pacing only, default two ticks

// ==========================================
// Register byte offsets
`define AQS_A_CTRL    8'h00
`define AQS_A_SRC     8'h04
`define AQS_A_PRE     8'h08
`define AQS_A_POST    8'h0C
`define AQS_A_DIV     8'h10
`define AQS_A_DELAY   8'h14
`define AQS_A_CMD     8'h18
`define AQS_A_STATUS  8'h1C
`define AQS_A_DATA    8'h20
`define AQS_A_COUNT   8'h24

// ==========================================
// Control fields
`define AQS_C_MODE       0
`define AQS_C_CONT       2
`define AQS_C_REF_EN     3
`define AQS_C_PACE_FALL  4
`define AQS_C_START_SW   5
`define AQS_C_PAUSE_EN   6
`define AQS_C_START_FALL 7
`define AQS_C_REF_FALL   8
`define AQS_C_PAUSE_LOW  9
`define AQS_C_NCH        12
`define AQS_MODE_SWT     2'h0
`define AQS_MODE_BUF     2'h1
`define AQS_MODE_NBUF    2'h2

// ==========================================
// Source fields and codes
`define AQS_S_PACE   0
`define AQS_S_START  8
`define AQS_S_REF    16
`define AQS_S_PAUSE  24
`define AQS_PACE_DIV 5'h00
`define AQS_PACE_CTR 5'h01
`define AQS_PACE_SW  5'h02
`define AQS_PACE_EXT 5'h03
`define AQS_EXT_N    16

// ==========================================
// Command and status bits
`define AQS_K_START 0
`define AQS_K_STOP  1
`define AQS_K_SWP   2
`define AQS_K_CLR   3
`define AQS_T_RUN   0
`define AQS_T_DONE  1
`define AQS_T_FOVF  2
`define AQS_T_HOVF  3
`define AQS_T_REFOK 4
`define AQS_T_LEVEL 8

// ==========================================
// Reset values and sizes
`define AQS_RST_DIV   24'h0000FF
`define AQS_RST_DELAY 16'h0002
`define AQS_FIFO_AW   4
`define AQS_FIFO_FULL 5'h10
`define AQS_DMA_BLOCK 5'h08
`define AQS_DW        16
`endif

// file: design/aqs_pkg.sv
// Types shared by the acquisition sequencer
package aqs_pkg;
   typedef enum logic [2:0] {AQS_IDLE, AQS_WAIT, AQS_DELAY, AQS_PRE, AQS_ARMED, AQS_POST, AQS_CONT} aqs_state_t;
endpackage

// file: design/aqs_mem.sv
// Sample store of the FIFO with registered read data
`timescale 1ns/100ps
module aqs_mem #(
   parameter int AW = 4,
   parameter int DW = 16
) (
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         rdata <= '0;
      else
         rdata <= mem[raddr];
   end
endmodule

// file: design/aqs_sync.sv
// Three-flop synchroniser for pin inputs with agreement filter
`timescale 1ns/100ps
module aqs_sync #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] stable
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_stable;

   // A level counts only once the second and third stages agree
   always_comb
   begin
      next_stable = ((s2 ~^ s3) & s2) | ((s2 ^ s3) & stable);
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         s1     <= '0;
         s2     <= '0;
         s3     <= '0;
         stable <= '0;
      end
      else
      begin
         s1     <= din;
         s2     <= s1;
         s3     <= s2;
         stable <= next_stable;
      end
   end
endmodule

// file: design/aqs_seq.sv
// Acquisition sequencer top: APB registers, pacing, triggers, sample counter, FIFO
`timescale 1ns/100ps
`include "aqs_params.svh"
module aqs_seq (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [5:0]  PFT_IN,
   input  wire logic [7:0]  STL_IN,
   input  wire logic        STAR_IN,
   input  wire logic        CTR_IN,
   input  wire logic        START_TRIG_I,
   output logic             START_TRIG_O,
   output logic             START_TRIG_OE,
   output logic             CONV_STROBE,
   output logic [3:0]       CONV_CHAN,
   input  wire logic [15:0] ADC_DATA,
   input  wire logic        ADC_VALID,
   output logic             DMA_REQ,
   output logic [15:0]      DMA_DATA,
   input  wire logic        DMA_ACK,
   input  wire logic        HBUF_OVF
);
   aqs_pkg::aqs_state_t state;
   aqs_pkg::aqs_state_t next_state;
   logic [15:0] ctrl,   next_ctrl;
   logic [31:0] src,    next_src;
   logic [23:0] pre,    next_pre;
   logic [23:0] post,   next_post;
   logic [23:0] divisor, next_divisor;
   logic [15:0] delay,  next_delay;
   logic [23:0] cnt,    next_cnt;
   logic [15:0] dly,    next_dly;
   logic [23:0] div,    next_div;
   logic        busy,   next_busy;
   logic [3:0]  last,   next_last;
   logic [3:0]  ch,     next_ch;
   logic        strobe, next_strobe;
   logic        done,   next_done;
   logic        fovf,   next_fovf;
   logic        hovf,   next_hovf;
   logic        refok,  next_refok;
   logic        stout,  next_stout;
   logic [3:0]  wptr,   next_wptr;
   logic [3:0]  rptr,   next_rptr;
   logic [4:0]  level,  next_level;
   logic        stale,  next_stale;
   logic [31:0] prdata, next_prdata;
   logic        rvalid, next_rvalid;
   logic        pace_d, next_pace_d;
   logic        st_d,   next_st_d;
   logic        ref_d,  next_ref_d;
   logic [15:0] ext;
   logic [15:0] rdata;
   logic [31:0] rmux;
   logic [4:0]  psrc;
   logic        pace_lvl, tick, acc, in_run, pause_on;
   logic        st_lvl, st_edge, ref_lvl, ref_edge;
   logic        wr, rd_done, mapped, swt, finite, use_ref, begin_acq;
   logic        cmd_start, cmd_stop, cmd_swp, cmd_clr;
   logic        push, pop, dma_pop, apb_pop, full, empty;
   aqs_pkg::aqs_state_t run_st;

   // ==========================================
   // Pins and memory
   aqs_sync #(.W(`AQS_EXT_N)) u_sync (
      .clk    (CLK),
      .nrst   (NRST),
      .din    ({START_TRIG_I, STAR_IN, STL_IN, PFT_IN}),
      .stable (ext)
   );

   aqs_mem #(.AW(`AQS_FIFO_AW), .DW(`AQS_DW)) u_mem (
      .clk   (CLK),
      .nrst  (NRST),
      .we    (push),
      .waddr (wptr),
      .wdata (ADC_DATA),
      .raddr (rptr),
      .rdata (rdata)
   );

   // ==========================================
   // Decode
   assign wr        = PSEL && PENABLE && PWRITE;
   assign rd_done   = PSEL && PENABLE && !PWRITE && rvalid;
   assign cmd_start = wr && PADDR == `AQS_A_CMD && PWDATA[`AQS_K_START];
   assign cmd_stop  = wr && PADDR == `AQS_A_CMD && PWDATA[`AQS_K_STOP];
   assign cmd_swp   = wr && PADDR == `AQS_A_CMD && PWDATA[`AQS_K_SWP];
   assign cmd_clr   = wr && PADDR == `AQS_A_CMD && PWDATA[`AQS_K_CLR];
   assign swt       = ctrl[`AQS_C_MODE +: 2] == `AQS_MODE_SWT;
   assign finite    = !ctrl[`AQS_C_CONT];
   assign use_ref   = ctrl[`AQS_C_REF_EN] && finite;
   assign in_run    = state inside {aqs_pkg::AQS_PRE, aqs_pkg::AQS_ARMED, aqs_pkg::AQS_POST, aqs_pkg::AQS_CONT};
   assign run_st    = !finite ? aqs_pkg::AQS_CONT
                    : (use_ref ? (pre == '0 ? aqs_pkg::AQS_ARMED : aqs_pkg::AQS_PRE) : aqs_pkg::AQS_POST);

   // ==========================================
   // Triggers: all digital, picked from synchronised pins
   assign st_lvl   = ext[src[`AQS_S_START +: 4]] ^ ctrl[`AQS_C_START_FALL];
   assign ref_lvl  = ext[src[`AQS_S_REF +: 4]] ^ ctrl[`AQS_C_REF_FALL];
   assign st_edge  = st_lvl && !st_d;
   assign ref_edge = ref_lvl && !ref_d;
   assign pause_on = ctrl[`AQS_C_PAUSE_EN] && (ext[src[`AQS_S_PAUSE +: 4]] ^ ctrl[`AQS_C_PAUSE_LOW]);
   assign begin_acq = !swt && ((ctrl[`AQS_C_START_SW] && cmd_start && state == aqs_pkg::AQS_IDLE)
                    || (!ctrl[`AQS_C_START_SW] && state == aqs_pkg::AQS_WAIT && st_edge));

   // ==========================================
   // Pacing source and edge
   assign psrc = src[`AQS_S_PACE +: 5];
   always_comb
   begin
      pace_lvl = 1'b0;
      if (psrc == `AQS_PACE_CTR)
         pace_lvl = CTR_IN;
      else if (psrc >= `AQS_PACE_EXT && psrc < `AQS_PACE_EXT + 5'(`AQS_EXT_N - 1))
         pace_lvl = ext[4'(psrc - `AQS_PACE_EXT)];
      pace_lvl = pace_lvl ^ ctrl[`AQS_C_PACE_FALL];
      if (psrc == `AQS_PACE_DIV)
         tick = in_run && div == '0;
      else if (psrc == `AQS_PACE_SW)
         tick = cmd_swp;
      else
         tick = pace_lvl && !pace_d;
   end

   // Only the pacing clock paces, and only while running and not paused
   assign acc = tick && in_run && !pause_on && !busy && !swt;

   // ==========================================
   // FIFO flags
   assign full    = level == `AQS_FIFO_FULL;
   assign empty   = level == '0;
   assign push    = busy && ADC_VALID;
   assign dma_pop = DMA_REQ && DMA_ACK;
   assign apb_pop = rd_done && PADDR == `AQS_A_DATA && !empty
                    && ctrl[`AQS_C_MODE +: 2] == `AQS_MODE_NBUF;
   assign pop     = dma_pop || apb_pop;
   // Short tail is flushed once the acquisition has stopped
   assign DMA_REQ = ctrl[`AQS_C_MODE +: 2] == `AQS_MODE_BUF && !empty && !stale
                    && (level >= `AQS_DMA_BLOCK || state == aqs_pkg::AQS_IDLE);
   assign DMA_DATA = rdata;

   // ==========================================
   // Register bus
   always_comb
   begin
      mapped = 1'b1;
      rmux   = '0;
      unique case (PADDR)
         `AQS_A_CTRL:   rmux = {16'h0000, ctrl};
         `AQS_A_SRC:    rmux = src;
         `AQS_A_PRE:    rmux = {8'h00, pre};
         `AQS_A_POST:   rmux = {8'h00, post};
         `AQS_A_DIV:    rmux = {8'h00, divisor};
         `AQS_A_DELAY:  rmux = {16'h0000, delay};
         `AQS_A_CMD:    rmux = '0;
         `AQS_A_STATUS: rmux = {19'h00000, level, 3'h0, refok, hovf, fovf, done, state != aqs_pkg::AQS_IDLE};
         `AQS_A_DATA:   rmux = {16'h0000, rdata};
         `AQS_A_COUNT:  rmux = {8'h00, cnt};
         default:       mapped = 1'b0;
      endcase
   end
   // A pop leaves the read word stale for one cycle, so a data read waits
   assign PREADY  = PWRITE || rvalid;
   assign PSLVERR = PSEL && PENABLE && PREADY && !mapped;
   assign PRDATA  = prdata;

   // ==========================================
   // Sequencer
   always_comb
   begin
      next_state = state;   next_ctrl = ctrl;     next_src = src;
      next_pre = pre;       next_post = post;     next_divisor = divisor;
      next_delay = delay;   next_cnt = cnt;       next_dly = dly;
      next_div = div;       next_busy = busy;     next_last = last;
      next_ch = ch;         next_strobe = 1'b0;   next_done = done;
      next_fovf = fovf;     next_hovf = hovf;     next_refok = refok;
      next_stout = 1'b0;    next_wptr = wptr;     next_rptr = rptr;
      next_level = level;   next_prdata = prdata; next_rvalid = rvalid;
      next_pace_d = pace_lvl; next_st_d = st_lvl; next_ref_d = ref_lvl;
      next_stale = pop || (push && (empty || full));
      if (wr)
      begin
         unique case (PADDR)
            `AQS_A_CTRL:  next_ctrl = PWDATA[15:0];
            `AQS_A_SRC:   next_src = PWDATA;
            `AQS_A_PRE:   next_pre = PWDATA[23:0];
            `AQS_A_POST:  next_post = PWDATA[23:0];
            `AQS_A_DIV:   next_divisor = PWDATA[23:0];
            `AQS_A_DELAY: next_delay = PWDATA[15:0];
            default:      ;
         endcase
      end
      if (PSEL && !PWRITE && !rvalid && (!stale || PADDR != `AQS_A_DATA))
      begin
         next_prdata = rmux;
         next_rvalid = 1'b1;
      end
      if (rd_done)
         next_rvalid = 1'b0;
      if (cmd_clr)
      begin
         next_fovf = 1'b0;
         next_hovf = 1'b0;
      end
      if (HBUF_OVF && !finite && state != aqs_pkg::AQS_IDLE)
         next_hovf = 1'b1;
      if (in_run)
         next_div = (div == '0) ? divisor - 24'h000001 : div - 24'h000001;
      if (cmd_start && !swt && !ctrl[`AQS_C_START_SW] && state == aqs_pkg::AQS_IDLE)
         next_state = aqs_pkg::AQS_WAIT;
      if (begin_acq)
      begin
         next_done  = 1'b0;
         next_refok = 1'b0;
         next_stout = ctrl[`AQS_C_START_SW];
         next_cnt   = use_ref ? pre : post;
         next_dly   = delay;
         next_div   = '0;
         next_state = (psrc == `AQS_PACE_DIV) ? aqs_pkg::AQS_DELAY : run_st;
      end
      if (state == aqs_pkg::AQS_DELAY)
      begin
         next_dly = dly - 16'h0001;
         if (dly <= 16'h0001)
            next_state = run_st;
      end
      if (acc)
      begin
         unique case (state)
            aqs_pkg::AQS_PRE:
               if (cnt <= 24'h000001)
               begin
                  next_cnt   = '0;
                  next_state = aqs_pkg::AQS_ARMED;
               end
               else
                  next_cnt = cnt - 24'h000001;
            aqs_pkg::AQS_POST:
               if (cnt <= 24'h000001)
               begin
                  next_cnt   = '0;
                  next_state = aqs_pkg::AQS_IDLE;
                  next_done  = 1'b1;
               end
               else
                  next_cnt = cnt - 24'h000001;
            default: ;
         endcase
      end
      // Reference only counts once the pretrigger samples are in
      if (state == aqs_pkg::AQS_ARMED && ref_edge)
      begin
         next_refok = 1'b1;
         next_cnt   = post;
         next_state = aqs_pkg::AQS_POST;
      end
      if (cmd_stop)
         next_state = aqs_pkg::AQS_IDLE;
      // Conversion train: one pass over all channels per paced sample, channel 0 only when software-timed
      if (acc || (swt && cmd_swp && !busy))
      begin
         next_busy   = 1'b1;
         next_ch     = '0;
         next_strobe = 1'b1;
         next_last   = swt ? 4'h0 : ctrl[`AQS_C_NCH +: 4];
      end
      else if (push)
      begin
         if (ch == last)
            next_busy = 1'b0;
         else
         begin
            next_ch     = ch + 4'h1;
            next_strobe = 1'b1;
         end
      end
      // Full FIFO drops its oldest word rather than the new one
      if (push && full && !pop)
      begin
         next_wptr = wptr + 4'h1;
         next_rptr = rptr + 4'h1;
         next_fovf = 1'b1;
      end
      else
      begin
         if (push)
            next_wptr = wptr + 4'h1;
         if (pop)
            next_rptr = rptr + 4'h1;
         next_level = level + 5'(push) - 5'(pop);
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         state <= aqs_pkg::AQS_IDLE; ctrl <= '0; src <= '0;
         pre <= '0; post <= '0; divisor <= `AQS_RST_DIV; delay <= `AQS_RST_DELAY;
         cnt <= '0; dly <= '0; div <= '0; busy <= 1'b0; last <= '0; ch <= '0;
         strobe <= 1'b0; done <= 1'b0; fovf <= 1'b0; hovf <= 1'b0; refok <= 1'b0;
         stout <= 1'b0; wptr <= '0; rptr <= '0; level <= '0; stale <= 1'b0;
         prdata <= '0; rvalid <= 1'b0; pace_d <= 1'b0; st_d <= 1'b0; ref_d <= 1'b0;
      end
      else
      begin
         state <= next_state; ctrl <= next_ctrl; src <= next_src;
         pre <= next_pre; post <= next_post; divisor <= next_divisor; delay <= next_delay;
         cnt <= next_cnt; dly <= next_dly; div <= next_div; busy <= next_busy;
         last <= next_last; ch <= next_ch; strobe <= next_strobe; done <= next_done;
         fovf <= next_fovf; hovf <= next_hovf; refok <= next_refok; stout <= next_stout;
         wptr <= next_wptr; rptr <= next_rptr; level <= next_level; stale <= next_stale;
         prdata <= next_prdata; rvalid <= next_rvalid; pace_d <= next_pace_d;
         st_d <= next_st_d; ref_d <= next_ref_d;
      end
   end

   assign CONV_STROBE   = strobe;
   assign CONV_CHAN     = ch;
   assign START_TRIG_O  = stout;
   assign START_TRIG_OE = ctrl[`AQS_C_START_SW];

   // ==========================================
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   chk_swt_one_conv: assert property (swt && cmd_swp && !busy |=> CONV_STROBE && CONV_CHAN == 4'h0 && last == 4'h0)
      else $error("software convert did not strobe one channel");
   chk_dma_nonempty: assert property (DMA_REQ |-> !empty && !stale && !swt)
      else $error("dma request with no valid data");
   chk_cont_holds: assert property (state == aqs_pkg::AQS_CONT && !cmd_stop |=> state == aqs_pkg::AQS_CONT)
      else $error("continuous run ended without stop");
   chk_fifo_overwrite: assert property (push && full && !pop |=> fovf && full && rptr == $past(rptr) + 4'h1)
      else $error("full fifo did not overwrite and flag");
   chk_pre_load: assert property (begin_acq && use_ref |=> cnt == $past(pre))
      else $error("pretrigger count not loaded");
   chk_ref_ignored: assert property (state == aqs_pkg::AQS_PRE && ref_edge && !acc |=> state == aqs_pkg::AQS_PRE)
      else $error("early reference trigger not ignored");
   chk_post_end: assert property (state == aqs_pkg::AQS_POST && acc && cnt == 24'h000001 && !cmd_stop
                                  |=> state == aqs_pkg::AQS_IDLE && done && cnt == '0)
      else $error("finite acquisition did not end");
   chk_sw_start_pulse: assert property (begin_acq && ctrl[`AQS_C_START_SW] |=> START_TRIG_O && START_TRIG_OE ##1 !START_TRIG_O)
      else $error("software start pulse missing");
   chk_train_start: assert property (acc |=> CONV_STROBE && CONV_CHAN == 4'h0 && busy)
      else $error("sample did not start conversion train");
   chk_idle_quiet: assert property (!in_run && !busy && !swt |=> !CONV_STROBE)
      else $error("conversion while not acquiring");
   chk_pause_quiet: assert property (pause_on && !busy && !swt |=> !CONV_STROBE)
      else $error("conversion while paused");
endmodule

// file: verif/aqs_far_model.sv
// Far-side model: converter answering strobes and transfer engine taking words
`timescale 1ns/100ps
module aqs_far_model (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic        CONV_STROBE,
   output logic      [15:0] ADC_DATA = 16'h0000,
   output logic             ADC_VALID = 1'b0,
   input  wire logic        DMA_REQ,
   output logic             DMA_ACK = 1'b0,
   input  wire logic        STALL
);
   int lat = -1;
   // ==========================================
   // Converter answers in one to three cycles; idle bus toggles so stale data shows
   always @(posedge CLK)
   begin
      ADC_VALID <= NRST && lat == 0;
      ADC_DATA  <= (NRST && lat == 0) ? 16'($urandom) : ~ADC_DATA;
      if (!NRST || lat == 0)
         lat <= -1;
      else if (CONV_STROBE)
         lat <= $urandom_range(2, 0);
      else if (lat > 0)
         lat <= lat - 1;
   end
   // ==========================================
   // Transfer engine stalls at random, or throughout when held off
   always @(posedge CLK)
      DMA_ACK <= NRST && DMA_REQ && !DMA_ACK && !STALL && $urandom_range(1, 0) == 1;
endmodule

// file: verif/aqs_seq_tb.sv
// Self-checking bench of the acquisition sequencer
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module aqs_seq_tb;
   localparam logic [7:0] CMD = 8'h18;
   localparam logic [7:0] ST  = 8'h1C;
   logic        CLK = 1'b0, NRST = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, CTR_IN = 1'b0;
   logic        HBUF_OVF = 1'b0, stall = 1'b0, track = 1'b0, ee;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, r, ev, em;
   logic [15:0] ext = 16'h0000;
   logic        PREADY, PSLVERR, START_TRIG_O, START_TRIG_OE, CONV_STROBE, ADC_VALID, DMA_REQ, DMA_ACK;
   logic [3:0]  CONV_CHAN, exp_ch = 4'h0, last_ch = 4'h0;
   logic [15:0] ADC_DATA, DMA_DATA, dv;
   logic [15:0] exp_q[$];
   logic [31:0] exp_v[$], exp_m[$];
   logic        exp_e[$];
   int          n_errors = 0, total_checks = 0, conv_cnt = 0, st_cnt = 0, cyc = 0, t0, t1, div, c0, i;

   aqs_seq u_dut (.CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
      .PFT_IN(ext[5:0]), .STL_IN(ext[13:6]), .STAR_IN(ext[14]), .CTR_IN, .START_TRIG_I(ext[15]), .START_TRIG_O,
      .START_TRIG_OE, .CONV_STROBE, .CONV_CHAN, .ADC_DATA, .ADC_VALID, .DMA_REQ, .DMA_DATA, .DMA_ACK, .HBUF_OVF);
   aqs_far_model u_far (.CLK, .NRST, .CONV_STROBE, .ADC_DATA, .ADC_VALID, .DMA_REQ, .DMA_ACK, .STALL(stall));
   initial forever #10 CLK = ~CLK;

   // ==========================================
   // Result watcher: takes the oldest note whenever an output shows a result
   always @(posedge CLK)
   begin
      cyc++;
      if (ADC_VALID && track)
         exp_q.push_back(ADC_DATA);
      if (DMA_REQ && DMA_ACK && track)
      begin
         dv = exp_q.pop_front();
         `CHK("dma_data", dv, DMA_DATA)
      end
      if (CONV_STROBE)
      begin
         conv_cnt++;
         `CHK("conv_chan", exp_ch, CONV_CHAN)
         exp_ch = (exp_ch == last_ch) ? 4'h0 : exp_ch + 4'h1;
         if (CONV_CHAN == 4'h0)
            t1 = cyc;
         if (CONV_CHAN == 4'h0 && t0 < 0)
            t0 = cyc;
      end
      if (START_TRIG_O)
      begin
         st_cnt++;
         `CHK("start_oe", 1'b1, START_TRIG_OE)
      end
      if (PSEL && PENABLE && PREADY && !PWRITE)
      begin
         ev = exp_v.pop_front();
         em = exp_m.pop_front();
         ee = exp_e.pop_front();
         `CHK("prdata", ev, PRDATA & em)
         `CHK("pslverr", ee, PSLVERR)
      end
   end

   task automatic end_sim(input int bad);
      n_errors += bad;
      if (n_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Holds the request until ready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (PREADY !== 1'b1 && n < 50);
      r = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n == 50)
         end_sim(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, input logic e);
      exp_m.push_back(m);
      exp_v.push_back(v & m);
      exp_e.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      int n;
      for (n = 0; n < 300; n++)
      begin
         rd(ST, 32'h0, 32'h0, 1'b0);
         if ((r & m) === v)
            break;
      end
      if (n == 300)
         end_sim(1);
      // Conversions of the last sample may still be in flight after done
      wt(10);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge CLK);
   endtask

   task automatic go(input logic [3:0] lc);
      last_ch = lc;
      exp_ch = 4'h0;
      conv_cnt = 0;
      st_cnt = 0;
      t0 = -1;
      apb(1'b1, CMD, 32'h1);
   endtask

   task automatic drain;
      poll(32'h1F00, 32'h0);
      `CHK("drained", 0, exp_q.size())
   endtask

   // Source code 1 is the counter input, codes 3 and up the pins
   task automatic pin(input int k, input logic v);
      if (k == 1)
         CTR_IN <= v;
      else
         ext[k - 3] <= v;
      wt(10);
   endtask

   initial
   begin
      void'($urandom(32'h7EF07DA4));
      wt(3);
      NRST <= 1'b1;
      rd(8'h10, 32'hFFFFFFFF, 32'hFF, 1'b0);
      rd(8'h14, 32'hFFFFFFFF, 32'h2, 1'b0);
      rd(8'h3C, 32'hFFFFFFFF, 32'h0, 1'b1);
      track = 1'b1;
      div = 16 + $urandom_range(15, 0);
      apb(1'b1, 8'h00, 32'h1021);
      apb(1'b1, 8'h0C, 32'h5);
      apb(1'b1, 8'h10, 32'(div));
      go(4'h1);
      poll(32'h3, 32'h2);
      `CHK("samples", 10, conv_cnt)
      `CHK("period", 4 * div, t1 - t0)
      `CHK("sw_start", 1, st_cnt)
      drain();
      apb(1'b1, 8'h04, 32'h5);
      pin(5, 1'b1);
      pin(5, 1'b0);
      `CHK("idle", 10, conv_cnt)
      apb(1'b1, 8'h0C, 32'h1);
      // Odd codes pace on the falling edge, so the rising half must not count
      for (i = 1; i < 18; i++)
      begin
         apb(1'b1, 8'h00, 32'h21 | 32'(i % 2) << 4);
         apb(1'b1, 8'h04, 32'(i));
         go(4'h0);
         if (i == 2)
            apb(1'b1, CMD, 32'h4);
         else
         begin
            pin(i, 1'b1);
            `CHK("edge", 1 - i % 2, conv_cnt)
            pin(i, 1'b0);
         end
         poll(32'h3, 32'h2);
         `CHK("one_sample", 1, conv_cnt)
      end
      drain();
      track = 1'b0;
      stall <= 1'b1;
      // Hardware start on pin 15, pause on terminal 1
      apb(1'b1, 8'h00, 32'h45);
      apb(1'b1, 8'h04, 32'h01000F00);
      apb(1'b1, 8'h10, 32'hA);
      go(4'h0);
      pin(18, 1'b1);
      pin(18, 1'b0);
      wt(400);
      rd(ST, 32'hD, 32'h5, 1'b0);
      pin(4, 1'b1);
      c0 = conv_cnt;
      wt(40);
      `CHK("paused", c0, conv_cnt)
      pin(4, 1'b0);
      HBUF_OVF <= 1'b1;
      wt(1);
      HBUF_OVF <= 1'b0;
      wt(2);
      rd(ST, 32'hC, 32'hC, 1'b0);
      apb(1'b1, CMD, 32'h2);
      rd(ST, 32'h1, 32'h0, 1'b0);
      apb(1'b1, CMD, 32'h8);
      rd(ST, 32'hC, 32'h0, 1'b0);
      stall <= 1'b0;
      poll(32'h1F00, 32'h0);
      track = 1'b1;
      apb(1'b1, 8'h00, 32'h29);
      apb(1'b1, 8'h08, 32'h4);
      apb(1'b1, 8'h0C, 32'h3);
      apb(1'b1, 8'h10, 32'h14);
      go(4'h0);
      pin(3, 1'b1);
      pin(3, 1'b0);
      rd(ST, 32'h10, 32'h0, 1'b0);
      wt(150);
      c0 = conv_cnt;
      pin(3, 1'b1);
      pin(3, 1'b0);
      poll(32'h3, 32'h2);
      rd(ST, 32'h10, 32'h10, 1'b0);
      `CHK("post_count", 1'b1, (conv_cnt - c0) inside {3, 4})
      `CHK("pre_count", 1'b1, c0 >= 4)
      drain();
      apb(1'b1, 8'h00, 32'h22);
      apb(1'b1, 8'h0C, 32'h2);
      go(4'h0);
      poll(32'h3, 32'h2);
      for (i = 0; i < 2; i++)
         rd(8'h20, 32'hFFFF, 32'(exp_q.pop_front()), 1'b0);
      track = 1'b0;
      apb(1'b1, 8'h00, 32'h0);
      conv_cnt = 0;
      for (i = 1; i < 4; i++)
      begin
         apb(1'b1, CMD, 32'h4);
         wt(8);
         `CHK("sw_conv", i, conv_cnt)
      end
      end_sim(0);
   end
endmodule
